// File: common/scratchpad_pkg.sv
package scratchpad_pkg;
    // ----------------------------------------
    // core setup word fields
    // ----------------------------------------
    localparam int data_pad_present_bit = 23;
    localparam int instr_pad_present_bit = 24;
    // ----------------------------------------
    // fault control word fields
    // ----------------------------------------
    localparam int tag_redirect_bit = 28;
    // ----------------------------------------
    // scratchpad control word (reg 22 sel 3) fields and reset value
    // ----------------------------------------
    localparam int data_pad_enable_bit = 0;
    localparam int instr_pad_enable_bit = 1;
    localparam int shared_pad_enable_bit = 2;
    localparam int hit_predict_enable_bit = 4;
    localparam logic [31:0] pad_control_reset = 32'h0000_0010;
    localparam logic [31:0] pad_control_mask = 32'h0000_0017;
    // ----------------------------------------
    // tag views
    // ----------------------------------------
    localparam int tag_field_low = 12;
    localparam int base_field_high = 31;
    localparam int size_field_high = 19;
    localparam logic [7:0] tag_index_base = 8'h00;
    localparam logic [7:0] tag_index_size = 8'h01;
    // ----------------------------------------
    // build configuration
    // ----------------------------------------
    localparam logic [19:0] data_pad_base = 20'h00100;
    localparam logic [19:0] instr_pad_base = 20'h00200;
    localparam logic [7:0] data_pad_sections = 8'h01;
    localparam logic [7:0] instr_pad_sections = 8'h01;
    localparam int pad_word_bits = 10;
    localparam logic data_pad_built = 1'b1;
    localparam logic instr_pad_built = 1'b1;
    localparam logic data_pad_dma_built = 1'b1;
    // ----------------------------------------
    // cache operation kinds
    // ----------------------------------------
    typedef enum logic [1:0] {
        op_tag_read = 2'b00,
        op_tag_write = 2'b01,
        op_data_read = 2'b10,
        op_data_write = 2'b11
    } cache_op_t;
endpackage

// File: rtl/pad_memory.sv
`timescale 1ns/1ns
// dual port word memory, registered read data on both ports
module pad_memory
(
    input wire logic ref_clk,
    input wire logic a_en,
    input wire logic a_we,
    input wire logic [9:0] a_addr,
    input wire logic [31:0] a_wdata,
    output logic [31:0] a_rdata,
    input wire logic b_en,
    input wire logic b_we,
    input wire logic [9:0] b_addr,
    input wire logic [31:0] b_wdata,
    output logic [31:0] b_rdata
);
    logic [31:0] mem [0:1023];

    // ----------------------------------------
    // port a
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (a_en)
        begin
            if (a_we)
                mem[a_addr] <= a_wdata;
            a_rdata <= mem[a_addr];
        end
    end

    // ----------------------------------------
    // port b (same-address write collision: port b lands last)
    // ----------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (b_en)
        begin
            if (b_we)
                mem[b_addr] <= b_wdata;
            b_rdata <= mem[b_addr];
        end
    end
endmodule // pad_memory

// File: rtl/scratchpad_ram_control.sv
`timescale 1ns/1ns
// Contract
// - hit predict enable set at reset
// - remember pad hits, gate data cache
// - predict disabled means normal cache lookups
// - mpu builds predict without alignment needs
// - presence bits 23 and 24 read-only
// - redirect bit steers index ops to pads
// - tag 0 returns build base address
// - tag 1 returns size in 4K sections
// - enables: data, instr, shared bits
// - instr pad filled while disabled
// - data pad serves loads and stores
// - dma port shares data pad
// - shared pad open to all agents
// - shared pad gated by local bit 2
// - no coherence for shared pad
// - cache ops never reach shared pad
// - tag half pairing follows endianness
// - tags and sizes fixed at build
// - pad hit overrides data cache hit
module scratchpad_ram_control
(
    input wire logic ref_clk,
    input wire logic rst,
    // coprocessor register port
    input wire logic ctl_write,
    input wire logic [31:0] ctl_wdata,
    output logic [31:0] ctl_rdata,
    input wire logic fault_write,
    input wire logic [31:0] fault_wdata,
    output logic [31:0] fault_rdata,
    output logic [31:0] setup_rdata,
    input wire logic big_endian,
    // index cache operations
    input wire logic op_valid,
    input wire logic [1:0] op_kind,
    input wire logic op_instr_side,
    input wire logic [9:0] op_index,
    input wire logic [31:0] op_tag_low_in,
    input wire logic [31:0] op_tag_high_in,
    output logic [31:0] data_tag_low,
    output logic [31:0] instr_tag_low,
    output logic [31:0] tag_high,
    output logic op_to_cache,
    // core data access
    input wire logic ld_valid,
    input wire logic ld_write,
    input wire logic [31:0] ld_addr,
    input wire logic [31:0] ld_wdata,
    output logic [31:0] ld_rdata,
    output logic ld_pad_hit,
    output logic dcache_enable,
    // instruction fetch
    input wire logic if_valid,
    input wire logic [31:0] if_addr,
    output logic [31:0] if_rdata,
    output logic if_pad_hit,
    // dma port to data pad
    input wire logic dma_valid,
    input wire logic dma_write,
    input wire logic [9:0] dma_addr,
    input wire logic [31:0] dma_wdata,
    output logic [31:0] dma_rdata,
    // shared pad gate toward the cluster
    output logic shared_pad_grant
);
    // ----------------------------------------
    // control registers
    // ----------------------------------------
    logic [31:0] pad_control;
    logic [31:0] fault_control;
    logic predict_valid;
    logic [19:0] predict_page;

    wire logic predict_on = pad_control[scratchpad_pkg::hit_predict_enable_bit];
    wire logic data_on = pad_control[scratchpad_pkg::data_pad_enable_bit];
    wire logic instr_on = pad_control[scratchpad_pkg::instr_pad_enable_bit];
    wire logic shared_on = pad_control[scratchpad_pkg::shared_pad_enable_bit];
    wire logic redirect = fault_control[scratchpad_pkg::tag_redirect_bit];

    // control word writes; prediction enable comes up set
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            pad_control <= scratchpad_pkg::pad_control_reset;
        else if (ctl_write)
            pad_control <= ctl_wdata & scratchpad_pkg::pad_control_mask;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            fault_control <= 32'h0000_0000;
        else if (fault_write)
            fault_control <= fault_wdata;
    end

    // ----------------------------------------
    // address decode against build tags
    // ----------------------------------------
    // sizes are build constants; nothing writes the tag views
    wire logic [19:0] ld_page = ld_addr[31:12];
    wire logic [19:0] if_page = if_addr[31:12];
    wire logic [19:0] d_off = ld_page - scratchpad_pkg::data_pad_base;
    wire logic [19:0] i_off = if_page - scratchpad_pkg::instr_pad_base;
    wire logic d_in_range = (ld_page >= scratchpad_pkg::data_pad_base) &&
        (d_off < {12'h000, scratchpad_pkg::data_pad_sections});
    wire logic i_in_range = (if_page >= scratchpad_pkg::instr_pad_base) &&
        (i_off < {12'h000, scratchpad_pkg::instr_pad_sections});
    wire logic d_hit = data_on && scratchpad_pkg::data_pad_built && d_in_range;
    wire logic i_hit = instr_on && scratchpad_pkg::instr_pad_built && i_in_range;

    // physical compare every access, so any mapping predicts right
    wire logic predicted = predict_on && predict_valid && (predict_page == ld_page);
    // pad hit wins over any cache hit at the same address
    wire logic next_dcache_enable = !(predicted && d_hit);

    // ----------------------------------------
    // prediction buffer
    // ----------------------------------------
    // a single page entry keeps the buffer small; misses just cost power
    always_ff @(posedge ref_clk)
    begin
        if (rst || !predict_on)
            predict_valid <= 1'b0;
        else if (ld_valid && d_hit)
        begin
            predict_valid <= 1'b1;
            predict_page <= ld_page;
        end
        else if (ld_valid && predicted && !d_hit)
            predict_valid <= 1'b0;
    end

    // ----------------------------------------
    // cache operation routing
    // ----------------------------------------
    // shared pad has no path here at all
    wire logic op_to_pad = op_valid && redirect;
    wire logic next_op_to_cache = op_valid && !redirect;
    wire logic op_is_tag = (op_kind == scratchpad_pkg::op_tag_read) ||
        (op_kind == scratchpad_pkg::op_tag_write);
    wire logic op_data_write = op_to_pad && (op_kind == scratchpad_pkg::op_data_write);
    wire logic op_data_read = op_to_pad && (op_kind == scratchpad_pkg::op_data_read);
    wire logic [7:0] tag_sel = op_index[7:0];
    wire logic [19:0] sel_base = op_instr_side ? scratchpad_pkg::instr_pad_base :
        scratchpad_pkg::data_pad_base;
    wire logic [7:0] sel_sections = op_instr_side ? scratchpad_pkg::instr_pad_sections :
        scratchpad_pkg::data_pad_sections;
    wire logic [31:0] tag_view = (tag_sel == scratchpad_pkg::tag_index_base) ?
        {sel_base, 12'h000} :
        (tag_sel == scratchpad_pkg::tag_index_size) ?
        {12'h000, sel_sections, 12'h000} : 32'h0000_0000;
    // word pairing of the two data tag registers flips with endianness
    wire logic [9:0] op_word = {op_index[9:1], op_index[0] ^ big_endian};
    wire logic [31:0] op_wdata = big_endian ? op_tag_high_in : op_tag_low_in;

    // ----------------------------------------
    // pad memories
    // ----------------------------------------
    logic [31:0] d_core_rdata;
    logic [31:0] i_core_rdata;
    logic [31:0] i_fetch_rdata;
    wire logic d_op = (op_data_write || op_data_read) && !op_instr_side;
    wire logic i_op = (op_data_write || op_data_read) && op_instr_side;
    // core port serves loads and stores; op traffic shares it when no load hits the pad
    wire logic d_core_en = (ld_valid && d_hit) || d_op;
    wire logic d_core_we = (ld_valid && d_hit) ? ld_write : op_data_write;
    wire logic [9:0] d_core_addr = (ld_valid && d_hit) ? ld_addr[11:2] : op_word;
    wire logic [31:0] d_core_wdata = (ld_valid && d_hit) ? ld_wdata : op_wdata;

    pad_memory data_pad
    (
        .ref_clk(ref_clk),
        .a_en(d_core_en),
        .a_we(d_core_we),
        .a_addr(d_core_addr),
        .a_wdata(d_core_wdata),
        .a_rdata(d_core_rdata),
        .b_en(dma_valid && scratchpad_pkg::data_pad_dma_built),
        .b_we(dma_write),
        .b_addr(dma_addr),
        .b_wdata(dma_wdata),
        .b_rdata(dma_rdata)
    );

    // instr pad loads by index stores even while disabled
    pad_memory instr_pad
    (
        .ref_clk(ref_clk),
        .a_en(i_op),
        .a_we(op_data_write),
        .a_addr(op_word),
        .a_wdata(op_wdata),
        .a_rdata(i_core_rdata),
        .b_en(if_valid && i_hit),
        .b_we(1'b0),
        .b_addr(if_addr[11:2]),
        .b_wdata(32'h0000_0000),
        .b_rdata(i_fetch_rdata)
    );

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    logic op_pending;
    logic op_pending_instr;
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            op_pending <= 1'b0;
            op_pending_instr <= 1'b0;
            ld_pad_hit <= 1'b0;
            if_pad_hit <= 1'b0;
            dcache_enable <= 1'b1;
            op_to_cache <= 1'b0;
            shared_pad_grant <= 1'b0;
        end
        else
        begin
            op_pending <= op_data_read;
            op_pending_instr <= op_instr_side;
            ld_pad_hit <= ld_valid && d_hit;
            if_pad_hit <= if_valid && i_hit;
            dcache_enable <= next_dcache_enable;
            op_to_cache <= next_op_to_cache;
            // local gate only; no coherence across cores
            shared_pad_grant <= shared_on;
        end
    end

    assign ld_rdata = d_core_rdata;
    assign if_rdata = i_fetch_rdata;

    // tag low views update on redirected tag reads or read data return
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            data_tag_low <= 32'h0000_0000;
            instr_tag_low <= 32'h0000_0000;
            tag_high <= 32'h0000_0000;
        end
        else if (op_to_pad && op_is_tag && (op_kind == scratchpad_pkg::op_tag_read))
        begin
            if (op_instr_side)
                instr_tag_low <= tag_view;
            else
                data_tag_low <= tag_view;
        end
        else if (op_pending)
        begin
            if (op_pending_instr)
                instr_tag_low <= i_core_rdata;
            else
                data_tag_low <= d_core_rdata;
            tag_high <= op_pending_instr ? i_core_rdata : d_core_rdata;
        end
    end

    // readback words; presence bits mirror the build
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            ctl_rdata <= scratchpad_pkg::pad_control_reset;
            fault_rdata <= 32'h0000_0000;
            setup_rdata <= 32'h0000_0000;
        end
        else
        begin
            ctl_rdata <= pad_control;
            fault_rdata <= fault_control;
            setup_rdata <= 32'h0000_0000;
            setup_rdata[scratchpad_pkg::data_pad_present_bit] <=
                scratchpad_pkg::data_pad_built;
            setup_rdata[scratchpad_pkg::instr_pad_present_bit] <=
                scratchpad_pkg::instr_pad_built;
        end
    end
endmodule // scratchpad_ram_control

// File: dv/pad_ctl_checker.sv
`timescale 1ns/1ns
// ----------------------------------------
// port-level checks on the pad controller
// ----------------------------------------
module pad_ctl_checker
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ctl_write,
    input wire logic [31:0] ctl_wdata,
    input wire logic [31:0] ctl_rdata,
    input wire logic [31:0] fault_rdata,
    input wire logic [31:0] setup_rdata,
    input wire logic op_valid,
    input wire logic [1:0] op_kind,
    input wire logic op_instr_side,
    input wire logic [9:0] op_index,
    input wire logic [31:0] data_tag_low,
    input wire logic op_to_cache,
    input wire logic ld_valid,
    input wire logic [31:0] ld_addr,
    input wire logic ld_pad_hit,
    input wire logic dcache_enable,
    input wire logic dma_valid,
    input wire logic dma_write,
    input wire logic [9:0] dma_addr,
    input wire logic [31:0] dma_wdata,
    input wire logic [31:0] dma_rdata,
    input wire logic shared_pad_grant
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // load target decode, sampled one cycle before the hit flag
    wire hit_now = ctl_rdata[0] && ld_addr[31:12] == scratchpad_pkg::data_pad_base;
    sequence base_read;
        op_valid && op_kind == 2'h0 && !op_instr_side && op_index[7:0] == 8'h00
            && fault_rdata[28];
    endsequence
    sequence dma_store;
        dma_valid && dma_write;
    endsequence
    // reset must not be masked here, so the default disable is overridden
    chk_reset_values: assert property (disable iff (1'b0) rst |=>
        ctl_rdata == scratchpad_pkg::pad_control_reset && dcache_enable && !shared_pad_grant)
        else $error("control word wrong after reset");
    chk_ctl_write: assert property (ctl_write |-> ##2
        ctl_rdata == ($past(ctl_wdata, 2) & scratchpad_pkg::pad_control_mask))
        else $error("control word not written");
    chk_setup_bits: assert property (!rst |=> setup_rdata == 32'h0180_0000)
        else $error("presence bits wrong");
    chk_grant_copy: assert property (shared_pad_grant == ctl_rdata[2])
        else $error("shared grant differs from enable");
    chk_op_cache: assert property (op_valid && !fault_rdata[28] |=> op_to_cache)
        else $error("op not sent to cache");
    chk_op_redirect: assert property (op_valid && fault_rdata[28] |=> !op_to_cache)
        else $error("redirected op reached cache");
    chk_cache_idle: assert property (!op_valid |=> !op_to_cache)
        else $error("cache op without request");
    chk_pred_off: assert property (!ctl_rdata[4] [*2] |-> dcache_enable)
        else $error("cache gated with prediction off");
    chk_load_hit: assert property (ld_valid |=> ld_pad_hit == $past(hit_now))
        else $error("pad hit flag wrong");
    chk_base_tag: assert property (base_read |-> ##[1:2]
        data_tag_low[31:12] == scratchpad_pkg::data_pad_base)
        else $error("base tag wrong");
    chk_dma_readback: assert property (dma_store ##2
        (dma_valid && !dma_write && dma_addr == $past(dma_addr, 2))
        |=> dma_rdata == $past(dma_wdata, 3))
        else $error("dma readback wrong");
endmodule // pad_ctl_checker

// File: dv/scratchpad_ram_control_bench.sv
`timescale 1ns/1ns
// ----------------------------------------
// bench top
// ----------------------------------------
module scratchpad_ram_control_bench;
    logic ref_clk = 1'b0, rst = 1'b1, ctl_write = 1'b0, fault_write = 1'b0, big_endian = 1'b0;
    logic op_valid = 1'b0, op_instr_side = 1'b0, ld_valid = 1'b0, ld_write = 1'b0;
    logic if_valid = 1'b0, dma_valid = 1'b0, dma_write = 1'b0;
    logic [1:0] op_kind = 2'h0;
    logic [9:0] op_index = 10'h000, dma_addr = 10'h000;
    logic [31:0] ctl_wdata = 32'h0, fault_wdata = 32'h0, op_tag_low_in = 32'hffff_f000;
    logic [31:0] op_tag_high_in = 32'hffff_f000, ld_addr = 32'h0, ld_wdata = 32'h0;
    logic [31:0] if_addr = 32'h0, dma_wdata = 32'h0;
    logic [31:0] ctl_rdata, fault_rdata, setup_rdata, data_tag_low, instr_tag_low, tag_high;
    logic [31:0] ld_rdata, if_rdata, dma_rdata;
    logic op_to_cache, ld_pad_hit, dcache_enable, if_pad_hit, shared_pad_grant;
    int n_errors = 0, num_checks = 0;
    localparam logic [31:0] dbase = {scratchpad_pkg::data_pad_base, 12'h000};
    localparam logic [31:0] ibase = {scratchpad_pkg::instr_pad_base, 12'h000};
    always #4 ref_clk = !ref_clk;
    scratchpad_ram_control dut_u (.ref_clk, .rst, .ctl_write, .ctl_wdata, .ctl_rdata,
        .fault_write, .fault_wdata, .fault_rdata, .setup_rdata, .big_endian, .op_valid,
        .op_kind, .op_instr_side, .op_index, .op_tag_low_in, .op_tag_high_in, .data_tag_low,
        .instr_tag_low, .tag_high, .op_to_cache, .ld_valid, .ld_write, .ld_addr, .ld_wdata,
        .ld_rdata, .ld_pad_hit, .dcache_enable, .if_valid, .if_addr, .if_rdata, .if_pad_hit,
        .dma_valid, .dma_write, .dma_addr, .dma_wdata, .dma_rdata, .shared_pad_grant);
    // ----------------------------------------
    // access tasks, all driven on the falling edge
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report();
        if (n_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // f selects the fault word, otherwise the pad control word;
    // readback lags the word by a cycle, so one idle cycle follows
    task automatic wreg(input logic f, input logic [31:0] v);
        @(negedge ref_clk);
        ctl_write = !f;
        fault_write = f;
        ctl_wdata = v;
        fault_wdata = v;
        @(negedge ref_clk);
        ctl_write = 1'b0;
        fault_write = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic cop(input logic [1:0] k, input logic s, input logic [9:0] i);
        @(negedge ref_clk);
        op_valid = 1'b1;
        op_kind = k;
        op_instr_side = s;
        op_index = i;
        @(negedge ref_clk);
        op_valid = 1'b0;
    endtask
    // p: 0 core data, 1 dma, 2 fetch; outputs are settled on return
    task automatic acc(input logic [1:0] p, input logic w, input logic [31:0] a,
        input logic [31:0] v);
        @(negedge ref_clk);
        ld_valid = p == 2'h0;
        dma_valid = p == 2'h1;
        if_valid = p == 2'h2;
        ld_write = w;
        dma_write = w;
        ld_addr = a;
        if_addr = a;
        dma_addr = a[9:0];
        ld_wdata = v;
        dma_wdata = v;
        @(negedge ref_clk);
        ld_valid = 1'b0;
        dma_valid = 1'b0;
        if_valid = 1'b0;
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk("ctl", scratchpad_pkg::pad_control_reset, ctl_rdata);
        chk("setup", 32'h0180_0000, setup_rdata);
        wreg(1'b0, 32'hffff_ffff);
        chk("ctl", 32'h0000_0017, ctl_rdata);
        chk("grant", 32'h1, shared_pad_grant);
        wreg(1'b0, 32'h0000_0011);
        chk("grant", 32'h0, shared_pad_grant);
        cop(2'h0, 1'b0, 10'h000);
        chk("to_cache", 32'h1, op_to_cache);
        wreg(1'b1, 32'h1000_0000);
        chk("fault", 32'h1000_0000, fault_rdata);
        cop(2'h0, 1'b0, 10'h000);
        chk("to_cache", 32'h0, op_to_cache);
        @(negedge ref_clk);
        chk("dbase", dbase, data_tag_low & 32'hffff_f000);
        cop(2'h0, 1'b1, 10'h000);
        @(negedge ref_clk);
        chk("ibase", ibase, instr_tag_low & 32'hffff_f000);
        cop(2'h0, 1'b0, 10'h001);
        @(negedge ref_clk);
        chk("dsize", {12'h000, scratchpad_pkg::data_pad_sections, 12'h000},
            data_tag_low & 32'h000f_f000);
        cop(2'h1, 1'b0, 10'h000);
        cop(2'h0, 1'b0, 10'h000);
        @(negedge ref_clk);
        chk("dbase", dbase, data_tag_low & 32'hffff_f000);
        // fill the instruction pad while it is still off
        op_tag_low_in = 32'h1234_5678;
        op_tag_high_in = 32'h9abc_def0;
        cop(2'h3, 1'b1, 10'h005);
        // index load of the same word comes back through the tag view
        cop(2'h2, 1'b1, 10'h005);
        @(negedge ref_clk);
        chk("itag_rd", 32'h1234_5678, instr_tag_low);
        big_endian = 1'b1;
        cop(2'h3, 1'b1, 10'h006);
        big_endian = 1'b0;
        wreg(1'b0, 32'h0000_0013);
        acc(2'h2, 1'b0, ibase | 32'h14, 32'h0);
        chk("fetch", 32'h1234_5678, if_rdata);
        chk("if_hit", 32'h1, if_pad_hit);
        acc(2'h2, 1'b0, ibase | 32'h1c, 32'h0);
        chk("fetch", 32'h9abc_def0, if_rdata);
        // data pad as plain memory, then prediction on repeated hits
        acc(2'h0, 1'b1, dbase | 32'h0c, 32'hcafe_0001);
        acc(2'h0, 1'b0, dbase | 32'h0c, 32'h0);
        chk("ld", 32'hcafe_0001, ld_rdata);
        chk("ld_hit", 32'h1, ld_pad_hit);
        chk("dc_en", 32'h0, dcache_enable);
        acc(2'h0, 1'b0, 32'h0000_0040, 32'h0);
        chk("ld_hit", 32'h0, ld_pad_hit);
        chk("dc_en", 32'h1, dcache_enable);
        wreg(1'b0, 32'h0000_0003);
        acc(2'h0, 1'b0, dbase | 32'h0c, 32'h0);
        acc(2'h0, 1'b0, dbase | 32'h0c, 32'h0);
        chk("dc_en", 32'h1, dcache_enable);
        acc(2'h1, 1'b1, 32'h14, 32'h5a5a_0014);
        acc(2'h1, 1'b0, 32'h14, 32'h0);
        chk("dma", 32'h5a5a_0014, dma_rdata);
        acc(2'h0, 1'b0, dbase | 32'h50, 32'h0);
        chk("ld", 32'h5a5a_0014, ld_rdata);
        wreg(1'b0, 32'h0000_0000);
        acc(2'h0, 1'b0, dbase | 32'h0c, 32'h0);
        chk("ld_hit", 32'h0, ld_pad_hit);
        final_report();
    end
    // hang guard, well beyond the length of the sequence
    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end
endmodule // scratchpad_ram_control_bench
bind scratchpad_ram_control pad_ctl_checker chk_u (.ref_clk, .rst, .ctl_write, .ctl_wdata,
    .ctl_rdata, .fault_rdata, .setup_rdata, .op_valid, .op_kind, .op_instr_side, .op_index,
    .data_tag_low, .op_to_cache, .ld_valid, .ld_addr, .ld_pad_hit, .dcache_enable,
    .dma_valid, .dma_write, .dma_addr, .dma_wdata, .dma_rdata, .shared_pad_grant);
